/* File: dcq_top.sv */
// Function
// - flags rise at once, clear after crossing
// - empty flags clear after pop-side sync ticks
// - full flags clear after push-side sync ticks
// - one word stored per push tick when enabled
// - start empty: empty high, full flags low
// - empty clears after first write, synced delay
// - almost-empty clears at threshold fill level
// - almost-full rises when level N-2 written
// - full rises when last word is written
// - writes while full are discarded, pointer held
// - full clears two ticks after freeing read
// - words delivered in write order per tick
// - almost-empty then empty rise while draining
// - output register adds one pop tick delay
// - flag timing independent of output register
// - gated output register moves only on pop ticks while pop enabled
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "dcq_map.svh"

module dcq_tick #(
    parameter int DIV = 2
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    output logic      tick
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;

    always_comb
    begin
        cnt_next = (cnt_reg == 16'(DIV - 1)) ? 16'h0000 : cnt_reg + 16'h0001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_reg <= 16'h0000;
        else
            cnt_reg <= cnt_next;
    end

    assign tick = (cnt_reg == 16'(DIV - 1));
endmodule

module dcq_stage #(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0]   cnt_reg, cnt_next;
    logic          put, take;

    always_comb
    begin
        put      = in_valid && in_ready;
        take     = out_valid && out_ready;
        wp_next  = put ? ((wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1) : wp_reg;
        rp_next  = take ? ((rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1) : rp_reg;
        cnt_next = cnt_reg + (AW+1)'(put) - (AW+1)'(take);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
        if (put)
            mem[wp_reg] <= in_data;
    end

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rp_reg];
endmodule

module dcq_top
    import dcq_pkg::*;
#(
    parameter int DW       = 32,
    parameter int DEPTH    = `DCQ_DEPTH,
    parameter int AE_LEVEL = `DCQ_AE_LEVEL,
    parameter int AF_LEVEL = `DCQ_DEPTH - `DCQ_AF_GAP,
    parameter int PUSH_DIV = `DCQ_PUSH_DIV,
    parameter int POP_DIV  = `DCQ_POP_DIV
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // write address and data
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    // write response
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // read address and data
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // queue state
    output dcq_flags_t         flags,
    output logic [DW-1:0]      pop_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_C = (AW+1)'(DEPTH);
    localparam logic [AW:0] AE_C   = (AW+1)'(AE_LEVEL);
    localparam logic [AW:0] AF_C   = (AW+1)'(AF_LEVEL);

    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--)
            b[i] = b[i+1] ^ g[i];
        return b;
    endfunction

    logic push_tick, pop_tick;
    dcq_tick #(.DIV(PUSH_DIV)) u_push_tick (.aclk(aclk), .aresetn(aresetn), .tick(push_tick));
    dcq_tick #(.DIV(POP_DIV))  u_pop_tick  (.aclk(aclk), .aresetn(aresetn), .tick(pop_tick));

    // bus side state
    dcq_wr_state_t wst_reg, wst_next;
    logic          aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [7:0]    waddr_reg, waddr_next;
    logic [31:0]   wdata_reg, wdata_next;
    logic [3:0]    wstrb_reg, wstrb_next;
    logic [1:0]    bresp_reg, bresp_next;
    logic          rvalid_reg, rvalid_next;
    logic [31:0]   rdata_reg, rdata_next;
    logic [1:0]    rresp_reg, rresp_next;
    dcq_ctrl_t     ctrl_reg, ctrl_next;
    logic          commit, is_push, ptr_rst, clear;

    // staging buffer between bus and push side
    logic          st_valid, st_ready, st_take;
    logic [DW-1:0] st_data;

    // queue state
    logic [DW-1:0] mem [DEPTH];
    logic [AW:0]   wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0]   rs1_reg, rs2_reg, ws1_reg, ws2_reg;
    logic [AW:0]   rs_next, ws_next;
    logic [AW:0]   wlevel, rlevel;
    logic [DW-1:0] q1_reg, q1_next, q2_reg, q2_next;
    logic          push_try, wr_fire, rd_fire;

    assign is_push = (waddr_reg == `DCQ_OFF_PUSH);
    // a push write waits for room so back-pressure reaches the bus master
    assign commit  = (wst_reg == DCQ_WR_COLLECT) && aw_have_reg && w_have_reg
                     && (!is_push || st_ready);
    assign ptr_rst = commit && (waddr_reg == `DCQ_OFF_CTRL) && wstrb_reg[1]
                     && wdata_reg[`DCQ_CTRL_PTR_RST];
    assign clear   = commit && (waddr_reg == `DCQ_OFF_CTRL) && wstrb_reg[1]
                     && wdata_reg[`DCQ_CTRL_CLEAR];

    dcq_stage #(.W(DW), .DEPTH(`DCQ_STAGE_DEPTH)) u_stage (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (commit && is_push),
        .in_ready  (st_ready),
        .in_data   (wdata_reg[DW-1:0]),
        .out_valid (st_valid),
        .out_ready (st_take),
        .out_data  (st_data)
    );

    always_comb
    begin
        wst_next     = wst_reg;
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        waddr_next   = waddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bresp_next   = bresp_reg;
        ctrl_next    = ctrl_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_next = 1'b1;
            waddr_next   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
        end
        if (commit)
        begin
            wst_next   = DCQ_WR_RESP;
            bresp_next = `DCQ_RESP_OKAY;
            case (waddr_reg)
                `DCQ_OFF_CTRL:
                begin
                    if (wstrb_reg[0])
                        ctrl_next = dcq_ctrl_t'(wdata_reg[3:0]);
                end
                `DCQ_OFF_PUSH, `DCQ_OFF_POP, `DCQ_OFF_STATUS:
                    bresp_next = `DCQ_RESP_OKAY;
                default:
                    bresp_next = `DCQ_RESP_SLVERR;
            endcase
        end
        if (wst_reg == DCQ_WR_RESP && s_axi_bready)
        begin
            wst_next     = DCQ_WR_COLLECT;
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wst_reg     <= DCQ_WR_COLLECT;
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            waddr_reg   <= 8'h00;
            wdata_reg   <= 32'h00000000;
            wstrb_reg   <= 4'h0;
            bresp_reg   <= `DCQ_RESP_OKAY;
            ctrl_reg    <= dcq_ctrl_t'(`DCQ_CTRL_RESET);
        end
        else
        begin
            wst_reg     <= wst_next;
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            waddr_reg   <= waddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bresp_reg   <= bresp_next;
            ctrl_reg    <= ctrl_next;
        end
    end

    assign s_axi_awready = (wst_reg == DCQ_WR_COLLECT) && !aw_have_reg;
    assign s_axi_wready  = (wst_reg == DCQ_WR_COLLECT) && !w_have_reg;
    assign s_axi_bvalid  = (wst_reg == DCQ_WR_RESP);
    assign s_axi_bresp   = bresp_reg;

    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
        if (s_axi_arvalid && !rvalid_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next  = `DCQ_RESP_OKAY;
            rdata_next  = 32'h00000000;
            case (s_axi_araddr)
                `DCQ_OFF_CTRL:   rdata_next[3:0] = ctrl_reg;
                `DCQ_OFF_PUSH:   rdata_next = 32'h00000000;
                `DCQ_OFF_POP:    rdata_next[DW-1:0] = pop_data;
                `DCQ_OFF_STATUS:
                begin
                    rdata_next[`DCQ_STAT_EMPTY]  = flags.empty;
                    rdata_next[`DCQ_STAT_AEMPTY] = flags.almost_empty;
                    rdata_next[`DCQ_STAT_AFULL]  = flags.almost_full;
                    rdata_next[`DCQ_STAT_FULL]   = flags.full;
                    rdata_next[`DCQ_STAT_STAGE]  = !st_ready;
                end
                default:         rresp_next = `DCQ_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= `DCQ_RESP_OKAY;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // push side: runs only on push ticks, sees the pop pointer two ticks late
    assign wlevel   = wp_reg - g2b(rs2_reg);
    assign push_try = push_tick && ctrl_reg.push_en && st_valid;
    assign wr_fire  = push_try && !flags.full;
    // a word offered while full is still drained from staging and lost
    assign st_take  = push_try;

    // pop side: runs only on pop ticks, sees the push pointer two ticks late
    assign rlevel  = g2b(ws2_reg) - rp_reg;
    assign rd_fire = pop_tick && ctrl_reg.pop_en && !flags.empty;

    always_comb
    begin
        wp_next = wr_fire ? wp_reg + 1'b1 : wp_reg;
        rp_next = rd_fire ? rp_reg + 1'b1 : rp_reg;
        if (ptr_rst)
            rp_next = '0;
        rs_next = rp_reg ^ (rp_reg >> 1);
        ws_next = wp_reg ^ (wp_reg >> 1);
        q1_next = rd_fire ? mem[rp_reg[AW-1:0]] : q1_reg;
        q2_next = q2_reg;
        if (pop_tick && (!ctrl_reg.out_gate || ctrl_reg.pop_en))
            q2_next = q1_reg;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || clear)
        begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            rs1_reg <= '0;
            rs2_reg <= '0;
            ws1_reg <= '0;
            ws2_reg <= '0;
            q1_reg  <= '0;
            q2_reg  <= '0;
        end
        else
        begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            q1_reg <= q1_next;
            q2_reg <= q2_next;
            if (push_tick)
            begin
                rs1_reg <= rs_next;
                rs2_reg <= rs1_reg;
            end
            if (pop_tick)
            begin
                ws1_reg <= ws_next;
                ws2_reg <= ws1_reg;
            end
        end
        if (wr_fire)
            mem[wp_reg[AW-1:0]] <= st_data;
    end

    // local pointer moves at once; the remote copy lags, so only clearing waits
    assign flags.full         = (wlevel == FULL_C);
    assign flags.almost_full  = (wlevel >= AF_C);
    assign flags.empty        = (rlevel == '0);
    assign flags.almost_empty = (rlevel < AE_C);
    // the output stage changes only data timing, never the flags
    assign pop_data = ctrl_reg.out_reg ? q2_reg : q1_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_full_discard: assert property (flags.full && push_try
        |=> wp_reg == $past(wp_reg) || $past(clear)) else $error("write taken while full");
    chk_empty_ignore: assert property (flags.empty && !ptr_rst && !clear
        |=> rp_reg == $past(rp_reg) && q1_reg == $past(q1_reg)) else $error("pop while empty");
    chk_push_advance: assert property (wr_fire && !clear
        |=> wp_reg == $past(wp_reg) + 1'b1) else $error("push not stored");
    // a pointer copy already in flight may legally move the remote view at this edge
    chk_empty_lag: assert property (flags.empty && wr_fire && !ptr_rst && ws1_reg == ws2_reg
        |=> flags.empty) else $error("empty cleared without sync delay");
    chk_full_lag: assert property (flags.full && rd_fire && !clear && rs1_reg == rs2_reg
        |=> flags.full) else $error("full cleared without sync delay");
    chk_full_rise: assert property (wr_fire && wlevel == FULL_C - 1'b1 && !clear
        && rs1_reg == rs2_reg
        |=> flags.full && flags.almost_full) else $error("full late");
    chk_ptr_reset: assert property (ptr_rst && !clear && !wr_fire
        |=> rp_reg == '0 && wp_reg == $past(wp_reg)) else $error("pointer reset wrong");
    chk_outreg_delay: assert property (pop_tick && !ctrl_reg.out_gate && !clear
        |=> q2_reg == $past(q1_reg)) else $error("output stage missed");
    chk_reset_flags: assert property ($rose(aresetn)
        |-> flags.empty && flags.almost_empty && !flags.full) else $error("bad start");

    cov_fill_full:  cover property (wr_fire ##1 flags.full);
    cov_drain:      cover property (rd_fire ##1 flags.empty);
    cov_discard:    cover property (flags.full && push_try);
    cov_stage_full: cover property (commit && is_push ##1 !st_ready);
endmodule

/* File: dcq_map.svh */
`ifndef DCQ_MAP_SVH
`define DCQ_MAP_SVH

// register byte offsets
`define DCQ_OFF_CTRL     8'h00
`define DCQ_OFF_PUSH     8'h04
`define DCQ_OFF_POP      8'h08
`define DCQ_OFF_STATUS   8'h0C

// control field positions
`define DCQ_CTRL_PUSH_EN 0
`define DCQ_CTRL_POP_EN  1
`define DCQ_CTRL_OUTREG  2
`define DCQ_CTRL_OUTGATE 3
`define DCQ_CTRL_PTR_RST 8
`define DCQ_CTRL_CLEAR   9
`define DCQ_CTRL_RESET   4'h0

// status field positions
`define DCQ_STAT_EMPTY   0
`define DCQ_STAT_AEMPTY  1
`define DCQ_STAT_AFULL   2
`define DCQ_STAT_FULL    3
`define DCQ_STAT_STAGE   4

// sizes and side rates, in aclk cycles per tick
`define DCQ_DEPTH        16
`define DCQ_AE_LEVEL     3
`define DCQ_AF_GAP       2
`define DCQ_STAGE_DEPTH  8
`define DCQ_PUSH_DIV     2
`define DCQ_POP_DIV      3

`define DCQ_RESP_OKAY    2'h0
`define DCQ_RESP_SLVERR  2'h2

`endif

/* File: dcq_pkg.sv */
package dcq_pkg;

    typedef enum logic [0:0] {
        DCQ_WR_COLLECT = 1'b0,
        DCQ_WR_RESP    = 1'b1
    } dcq_wr_state_t;

    typedef struct packed {
        logic full;
        logic almost_full;
        logic almost_empty;
        logic empty;
    } dcq_flags_t;

    typedef struct packed {
        logic out_gate;
        logic out_reg;
        logic pop_en;
        logic push_en;
    } dcq_ctrl_t;

endpackage

/* File: dcq_host.sv */
`timescale 1ns/100ps

module dcq_host (
    // clock
    input  wire logic        aclk,
    // write address and data
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    // write response
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // read address and data
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);

    initial
    begin
        s_axi_awaddr  = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
    end

    // address and data are offered together, each released at its own handshake edge
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // push writes may stall here while staging is full, so no cycle count is assumed
        while (!s_axi_bvalid)
            @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
            @(posedge aclk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid)
            @(posedge aclk);
        d    = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

endmodule

/* File: tb_dcq_top.sv */
`timescale 1ns/100ps
`include "dcq_map.svh"

module tb_dcq_top
    import dcq_pkg::*;
;
    localparam int DEPTH = 16;
    localparam int AE    = 3;
    localparam int AF    = 14;
    localparam logic [31:0] MODES [3] = '{32'h3, 32'h7, 32'hF};

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, pop_data;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    dcq_flags_t  flags;
    int          n_fail = 0;
    int          n_compared = 0;
    logic [31:0] seen [$];
    logic [31:0] last_pd = 32'h0;
    logic [31:0] rd;
    logic [1:0]  resp;

    always #20 aclk = ~aclk;

    dcq_top #(.DEPTH(DEPTH), .AE_LEVEL(AE), .AF_LEVEL(AF)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flags(flags), .pop_data(pop_data)
    );

    dcq_host host (
        .aclk(aclk),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    // records each new nonzero output word, so order and count can be judged afterwards
    always @(posedge aclk)
    begin
        if (aresetn && pop_data !== last_pd)
        begin
            if (pop_data !== 32'h0)
                seen.push_back(pop_data);
            last_pd = pop_data;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [3:0] exp_flags(input int n);
        return {n >= DEPTH, n >= AF, n < AE, n == 0};
    endfunction

    // status register and flag port must agree; staging is drained whenever this is called
    task automatic status_is(input logic [3:0] f);
        host.bus_rd(`DCQ_OFF_STATUS, rd, resp);
        check("status", {28'h0, f}, rd);
        check("flags", {28'h0, f}, {28'h0, flags});
    endtask

    task automatic results;
        $display("checks made %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        $display("watchdog expired");
        results();
    end

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        status_is(4'b0011);
        host.bus_rd(`DCQ_OFF_CTRL, rd, resp);
        check("ctrl reset", 32'h0, rd);
        host.bus_wr(8'h10, 32'h1, resp);
        check("unmapped write resp", 32'h2, {30'h0, resp});
        host.bus_rd(8'h10, rd, resp);
        check("unmapped read resp", 32'h2, {30'h0, resp});
        $display("test reset and map done");

        host.bus_wr(`DCQ_OFF_CTRL, 32'h1, resp);
        for (int n = 1; n <= DEPTH; n++)
        begin
            host.bus_wr(`DCQ_OFF_PUSH, 32'h1000 + n, resp);
            repeat (20) @(posedge aclk);
            status_is(exp_flags(n));
        end
        repeat (2) host.bus_wr(`DCQ_OFF_PUSH, 32'hDEAD, resp);
        repeat (20) @(posedge aclk);
        status_is(exp_flags(DEPTH));
        $display("test fill done");

        seen.delete();
        host.bus_wr(`DCQ_OFF_CTRL, 32'h2, resp);
        repeat (DEPTH * 3 + 30) @(posedge aclk);
        status_is(exp_flags(0));
        check("words out", DEPTH, seen.size());
        for (int i = 0; i < seen.size(); i++)
            check("word order", 32'h1000 + i + 1, seen[i]);
        repeat (30) @(posedge aclk);
        check("held output", 32'h1000 + DEPTH, pop_data);
        // pop pointer back to the start: the whole stored run comes out again
        seen.delete();
        host.bus_wr(`DCQ_OFF_CTRL, 32'h102, resp);
        repeat (DEPTH * 3 + 30) @(posedge aclk);
        check("reread words", DEPTH, seen.size());
        for (int i = 0; i < seen.size(); i++)
            check("reread order", 32'h1000 + i + 1, seen[i]);
        status_is(exp_flags(0));
        $display("test drain done");

        // plain, registered and gated output in turn; pop stays enabled through the extra stage
        for (int m = 0; m < 3; m++)
        begin
            host.bus_wr(`DCQ_OFF_CTRL, 32'h200, resp);
            repeat (10) @(posedge aclk);
            status_is(exp_flags(0));
            check("cleared output", 32'h0, pop_data);
            seen.delete();
            host.bus_wr(`DCQ_OFF_CTRL, MODES[m], resp);
            host.bus_rd(`DCQ_OFF_CTRL, rd, resp);
            check("ctrl readback", MODES[m], rd);
            for (int k = 0; k < 5; k++)
                host.bus_wr(`DCQ_OFF_PUSH, 32'h2000 + 16 * m + k, resp);
            repeat (60) @(posedge aclk);
            check("mode words out", 5, seen.size());
            for (int i = 0; i < seen.size(); i++)
                check("mode word order", 32'h2000 + 16 * m + i, seen[i]);
            status_is(exp_flags(0));
        end
        $display("test output modes done");
        results();
    end

endmodule
